// file: pd_bmc_timing_pkg.sv
package pd_bmc_timing_pkg;

	// Register byte addresses
	localparam logic [15:0] ADDR_SQ_HOLD   = 16'h1aa9;
	localparam logic [15:0] ADDR_TX_BIT    = 16'h1ab0;
	localparam logic [15:0] ADDR_WINDOW    = 16'h1ab1;
	localparam logic [15:0] ADDR_ST_CTL    = 16'h1ac0;
	localparam logic [15:0] ADDR_ST_ERR_HI = 16'h1ac2;
	localparam logic [15:0] ADDR_ST_ERR_LO = 16'h1ac3;

	// Reset values
	localparam logic [7:0]  RST_SQ_HOLD = 8'h00;
	localparam logic [7:0]  RST_TX_BIT  = 8'h00;
	localparam logic [7:0]  RST_WINDOW  = 8'h00;
	localparam logic        RST_ST_EN   = 1'b0;
	localparam logic [15:0] RST_ERRORS  = 16'h0000;

	// Field positions in the self-test control register
	localparam int ST_EN_BIT  = 4;
	localparam int ST_RSV_LSB = 5;

	// Core cycles per programmed count step
	localparam logic [9:0] CYC_PER_COUNT = 10'h004;
	// Extra cycle of the squelch hold interval
	localparam logic [9:0] HOLD_EXTRA    = 10'h001;
	// Transitions that mark an active line
	localparam logic [1:0] EDGES_ACTIVE  = 2'h3;

	// Receive PRBS checker, Galois form
	localparam logic [15:0] PRBS_SEED = 16'hffff;
	localparam logic [15:0] PRBS_TAPS = 16'hb400;

	typedef enum logic [1:0] {SQ_OFF, SQ_ON, SQ_HOLD} sq_state_t;

	typedef struct packed {
		logic [7:0] sq_hold;
		logic [7:0] tx_bit;
		logic [7:0] window;
		logic       st_en;
	} cfg_t;

	localparam cfg_t CFG_RST = '{
		sq_hold: RST_SQ_HOLD,
		tx_bit:  RST_TX_BIT,
		window:  RST_WINDOW,
		st_en:   RST_ST_EN
	};

	typedef struct packed {
		cfg_t       cfg;
		logic [7:0] rdata;
		logic       rx_prev;
		logic       active;
		logic [1:0] edge_cnt;
		logic [9:0] win_cnt;
		sq_state_t  sq_st;
		logic [8:0] run_cnt;
		logic [9:0] hold_cnt;
		logic [7:0] tx_cnt;
		logic       tx_line;
		logic       tx_data;
		logic [15:0] lfsr;
		logic [15:0] errors;
	} state_t;

endpackage

// file: pd_bmc_timing_bist_rx.sv
// Local design decision: the plain strobed port.
`timescale 1ns/100ps

// Notes on behaviour
// (R1) Squelch output stays active for the hold interval after the drop.
// (R2) Hold interval lasts programmed value times four plus one cycles.
// (R3) Software should program squelch hold to 23; resets to zero.
// (R4) Squelch drops when a level outlasts its maximum high or low time.
// (R5) Transmit bit period is bit-time count plus one cycles.
// (R6) Software should program bit-time count to 159 for 300 Kbps.
// (R7) Line is active after three transitions inside one window.
// (R8) Line goes idle after a full window without three transitions.
// (R9) Window lasts exactly programmed value times four cycles, no prescaler.
// (R10) Software keeps window between 12 and 20 us.
// (R11) Software should program window to 200; resets to zero.
// (R12) Bit 4 enables the self-test receiver; bits 7 to 5 read zero.
// (R13) Setting the enable reseeds the receive PRBS checker.
// (R14) Setting the enable clears the 16-bit error counter.
// (R15) Loopback self-test may be enabled with loopback on, auto response off.
// (R16) Software clears then sets the enable for each new request.
// (R17) Error count is 16 bits, read as upper and lower bytes.
// (R18) Reseed and clear happen only on a zero to one write.
module pd_bmc_timing_bist_rx
	import pd_bmc_timing_pkg::*;
(
	input  wire logic        I_CLK,
	input  wire logic        I_RST_N,
	input  wire logic [15:0] I_ADDR,
	input  wire logic [7:0]  I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output      logic [7:0]  O_RDATA,
	input  wire logic        I_RX_LINE,
	input  wire logic [7:0]  I_RX_HI_MAX,
	input  wire logic [7:0]  I_RX_LO_MAX,
	output      logic        O_RX_ACTIVE,
	output      logic        O_RX_SQUELCH,
	input  wire logic        I_TX_EN,
	input  wire logic        I_TX_BIT,
	output      logic        O_TX_BIT_TAKE,
	output      logic        O_TX_LINE,
	input  wire logic        I_ST_BIT_VALID,
	input  wire logic        I_ST_BIT,
	output      logic        O_ST_RX_EN,
	output      logic [15:0] O_ST_ERRORS
);

	function automatic logic [9:0] scale4(input logic [7:0] v);
		logic [9:0] wide;
		wide = {2'b00, v};
		return 10'(wide * CYC_PER_COUNT);
	endfunction

	state_t     s_r;
	state_t     s_nxt;
	logic       rx_edge;
	logic [1:0] ecount;
	logic [9:0] win_len;
	logic [7:0] run_lim;
	logic       sq_drop;
	logic [7:0] tx_half;
	logic       wr_ctl;
	logic       st_rise;
	logic       prbs_exp;
	logic [7:0] rd_mux;

	always_comb begin
		s_nxt   = s_r;
		rx_edge = I_RX_LINE ^ s_r.rx_prev;
		ecount  = (s_r.edge_cnt == EDGES_ACTIVE || !rx_edge) ?
			s_r.edge_cnt : s_r.edge_cnt + 2'h1;
		win_len = scale4(s_r.cfg.window);
		run_lim = I_RX_LINE ? I_RX_HI_MAX : I_RX_LO_MAX;
		sq_drop = !rx_edge && (s_r.run_cnt > {1'b0, run_lim}); // [R4]
		tx_half = 8'(({1'b0, s_r.cfg.tx_bit} + 9'h001) >> 1);
		wr_ctl  = I_WR && I_ADDR == ADDR_ST_CTL;
		st_rise = wr_ctl && I_WDATA[ST_EN_BIT] && !s_r.cfg.st_en; // [R18]
		prbs_exp = s_r.lfsr[15];

		// Register writes
		if (I_WR) begin
			unique case (I_ADDR)
				ADDR_SQ_HOLD: s_nxt.cfg.sq_hold = I_WDATA;
				ADDR_TX_BIT:  s_nxt.cfg.tx_bit = I_WDATA;
				ADDR_WINDOW:  s_nxt.cfg.window = I_WDATA;
				ADDR_ST_CTL:  s_nxt.cfg.st_en = I_WDATA[ST_EN_BIT]; // [R12]
				default: ;
			endcase
		end

		// Register reads, data valid in the next cycle only
		unique case (I_ADDR)
			ADDR_SQ_HOLD:   rd_mux = s_r.cfg.sq_hold;
			ADDR_TX_BIT:    rd_mux = s_r.cfg.tx_bit;
			ADDR_WINDOW:    rd_mux = s_r.cfg.window;
			ADDR_ST_CTL:    rd_mux = 8'(s_r.cfg.st_en) << ST_EN_BIT; // [R12]
			ADDR_ST_ERR_HI: rd_mux = s_r.errors[15:8]; // [R17]
			ADDR_ST_ERR_LO: rd_mux = s_r.errors[7:0]; // [R17]
			default:        rd_mux = 8'h00;
		endcase
		s_nxt.rdata = I_RD ? rd_mux : 8'h00;

		// Activity detection over the transition window
		s_nxt.rx_prev = I_RX_LINE;
		if (s_r.cfg.window == 8'h00) begin
			s_nxt.active   = 1'b0;
			s_nxt.edge_cnt = 2'h0;
			s_nxt.win_cnt  = 10'h000;
		end else if (!s_r.active && s_r.edge_cnt == 2'h0) begin
			if (rx_edge) begin
				// Edge cycle is the first of the window's cycles
				s_nxt.edge_cnt = 2'h1;
				s_nxt.win_cnt  = win_len - 10'h002; // [R9]
			end
		end else if (!s_r.active) begin
			if (ecount == EDGES_ACTIVE) begin
				s_nxt.active   = 1'b1; // [R7]
				s_nxt.edge_cnt = 2'h0;
				s_nxt.win_cnt  = win_len - 10'h001; // [R9]
			end else if (s_r.win_cnt == 10'h000) begin
				s_nxt.edge_cnt = 2'h0;
			end else begin
				s_nxt.edge_cnt = ecount;
				s_nxt.win_cnt  = s_r.win_cnt - 10'h001;
			end
		end else begin
			if (s_r.win_cnt == 10'h000) begin
				s_nxt.active   = (ecount == EDGES_ACTIVE); // [R8]
				s_nxt.edge_cnt = 2'h0;
				s_nxt.win_cnt  = win_len - 10'h001; // [R9]
			end else begin
				s_nxt.edge_cnt = ecount;
				s_nxt.win_cnt  = s_r.win_cnt - 10'h001;
			end
		end

		// Level run length for the squelch drop
		if (rx_edge) begin
			s_nxt.run_cnt = 9'h000;
		end else if (s_r.run_cnt != 9'h1ff) begin
			s_nxt.run_cnt = s_r.run_cnt + 9'h001;
		end

		// Squelch with hold
		unique case (s_r.sq_st)
			SQ_OFF: begin
				if (s_r.active) begin
					s_nxt.sq_st = SQ_ON;
				end
			end
			SQ_ON: begin
				if (sq_drop) begin
					s_nxt.sq_st    = SQ_HOLD; // [R1]
					s_nxt.hold_cnt = scale4(s_r.cfg.sq_hold); // [R2]
				end
			end
			SQ_HOLD: begin
				if (rx_edge) begin
					s_nxt.sq_st = SQ_ON;
				end else if (s_r.hold_cnt == 10'h000) begin
					s_nxt.sq_st = SQ_OFF;
				end else begin
					s_nxt.hold_cnt = s_r.hold_cnt - 10'h001; // [R2]
				end
			end
		endcase

		// Transmit bit timing and biphase-mark encoding
		if (!I_TX_EN) begin
			s_nxt.tx_cnt = 8'h00;
		end else begin
			if (s_r.tx_cnt == 8'h00) begin
				s_nxt.tx_line = !s_r.tx_line;
				s_nxt.tx_data = I_TX_BIT;
			end else if (s_r.tx_cnt == tx_half && s_r.tx_data) begin
				s_nxt.tx_line = !s_r.tx_line;
			end
			if (s_r.tx_cnt == s_r.cfg.tx_bit) begin
				s_nxt.tx_cnt = 8'h00; // [R5]
			end else begin
				s_nxt.tx_cnt = s_r.tx_cnt + 8'h01; // [R5]
			end
		end

		// Self-test receive checker
		if (st_rise) begin
			s_nxt.lfsr   = PRBS_SEED; // [R13]
			s_nxt.errors = RST_ERRORS; // [R14]
		end else if (s_r.cfg.st_en && I_ST_BIT_VALID) begin
			s_nxt.lfsr = prbs_exp ? ((s_r.lfsr << 1) ^ PRBS_TAPS) :
				(s_r.lfsr << 1);
			if (I_ST_BIT != prbs_exp && s_r.errors != 16'hffff) begin
				s_nxt.errors = s_r.errors + 16'h0001; // [R17]
			end
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			s_r      <= '0;
			s_r.cfg  <= CFG_RST;
			s_r.lfsr <= PRBS_SEED;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign O_RDATA       = s_r.rdata;
	assign O_RX_ACTIVE   = s_r.active;
	assign O_RX_SQUELCH  = s_r.sq_st != SQ_OFF;
	assign O_TX_BIT_TAKE = I_TX_EN && s_r.tx_cnt == 8'h00;
	assign O_TX_LINE     = s_r.tx_line;
	assign O_ST_RX_EN    = s_r.cfg.st_en;
	assign O_ST_ERRORS   = s_r.errors;

	// Checking helpers
	logic [9:0] hold_len_r;
	logic [9:0] hold_exp_r;
	logic [8:0] gap_r;
	logic       gap_ok_r;

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			hold_len_r <= 10'h000;
			hold_exp_r <= 10'h000;
			gap_r      <= 9'h000;
			gap_ok_r   <= 1'b0;
		end else begin
			hold_len_r <= (s_r.sq_st == SQ_HOLD) ?
				hold_len_r + 10'h001 : 10'h000;
			if (s_r.sq_st == SQ_ON && sq_drop) begin
				hold_exp_r <= scale4(s_r.cfg.sq_hold) + HOLD_EXTRA;
			end
			gap_r <= O_TX_BIT_TAKE ? 9'h001 : gap_r + 9'h001;
			if (!I_TX_EN || (I_WR && I_ADDR == ADDR_TX_BIT)) begin
				gap_ok_r <= 1'b0;
			end else if (O_TX_BIT_TAKE) begin
				gap_ok_r <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);

	property p_hold_kept;
		s_r.sq_st == SQ_ON && sq_drop |=> O_RX_SQUELCH &&
			s_r.hold_cnt == scale4($past(s_r.cfg.sq_hold));
	endproperty
	a_hold_kept: assert property (p_hold_kept) // [R1]
		else $error("squelch fell at hold start");

	property p_hold_len;
		$fell(O_RX_SQUELCH) |-> hold_len_r == hold_exp_r;
	endproperty
	a_hold_len: assert property (p_hold_len) // [R2]
		else $error("squelch hold length wrong");

	property p_drop;
		s_r.sq_st == SQ_ON && !rx_edge &&
			s_r.run_cnt > {1'b0, run_lim} |=> s_r.sq_st == SQ_HOLD;
	endproperty
	a_drop: assert property (p_drop) // [R4]
		else $error("squelch did not drop on long level");

	property p_tx_period;
		O_TX_BIT_TAKE && gap_ok_r && $past(I_TX_EN) |->
			gap_r == {1'b0, s_r.cfg.tx_bit} + 9'h001;
	endproperty
	a_tx_period: assert property (p_tx_period) // [R5]
		else $error("transmit bit period wrong");

	property p_tx_toggle;
		O_TX_BIT_TAKE |=> O_TX_LINE != $past(O_TX_LINE);
	endproperty
	a_tx_toggle: assert property (p_tx_toggle) // [R5]
		else $error("no transition at bit boundary");

	property p_act_rise;
		$rose(O_RX_ACTIVE) |-> $past(rx_edge) && $past(s_r.edge_cnt) == 2'h2;
	endproperty
	a_act_rise: assert property (p_act_rise) // [R7]
		else $error("activity without third transition");

	property p_act_fall;
		$fell(O_RX_ACTIVE) && $past(s_r.cfg.window) != 8'h00 |->
			$past(s_r.win_cnt) == 10'h000 && $past(ecount) != EDGES_ACTIVE;
	endproperty
	a_act_fall: assert property (p_act_fall) // [R8]
		else $error("idle declared before window end");

	property p_win_load;
		$rose(O_RX_ACTIVE) && $stable(s_r.cfg.window) |->
			s_r.win_cnt == scale4(s_r.cfg.window) - 10'h001;
	endproperty
	a_win_load: assert property (p_win_load) // [R9]
		else $error("window length wrong");

	property p_en_write;
		wr_ctl |=> O_ST_RX_EN == $past(I_WDATA[ST_EN_BIT]) ##1
			(I_WR || O_ST_RX_EN == $past(O_ST_RX_EN));
	endproperty
	a_en_write: assert property (p_en_write) // [R12]
		else $error("self-test enable not stored");

	property p_ctl_read;
		I_RD && I_ADDR == ADDR_ST_CTL |=>
			O_RDATA[7:ST_RSV_LSB] == 3'h0 &&
			O_RDATA[ST_EN_BIT] == $past(O_ST_RX_EN);
	endproperty
	a_ctl_read: assert property (p_ctl_read) // [R12]
		else $error("control read back wrong");

	property p_reseed;
		st_rise |=> s_r.lfsr == PRBS_SEED;
	endproperty
	a_reseed: assert property (p_reseed) // [R13]
		else $error("checker not reseeded");

	property p_clear;
		st_rise |=> O_ST_ERRORS == 16'h0000 && O_ST_RX_EN;
	endproperty
	a_clear: assert property (p_clear) // [R14]
		else $error("error count not cleared");

	property p_err_hi;
		I_RD && I_ADDR == ADDR_ST_ERR_HI |=>
			O_RDATA == $past(O_ST_ERRORS[15:8]);
	endproperty
	a_err_hi: assert property (p_err_hi) // [R17]
		else $error("upper error byte wrong");

	property p_no_reclear;
		wr_ctl && s_r.cfg.st_en |=> O_ST_ERRORS >= $past(O_ST_ERRORS);
	endproperty
	a_no_reclear: assert property (p_no_reclear) // [R18]
		else $error("error count cleared while enable stayed set");

	c_active:  cover property ($rose(O_RX_ACTIVE));
	c_hold:    cover property (s_r.sq_st == SQ_HOLD ##1 !O_RX_SQUELCH);
	c_tx:      cover property (O_TX_BIT_TAKE && gap_ok_r);
	c_err:     cover property (O_ST_ERRORS != 16'h0000);
	c_read:    cover property (I_RD ##1 O_RDATA != 8'h00);

endmodule

// file: cc_partner.sv
`timescale 1ns/100ps
module cc_partner (
	input  wire logic clk,
	output      logic line,
	output      logic st_valid,
	output      logic st_bit
);
	initial begin
		line = 1'b0;
		st_valid = 1'b0;
		st_bit = 1'b0;
	end
	// Line transitions spaced by gap cycles; the level rests afterwards
	task automatic edges(input int n, input int gap);
		repeat (n) begin
			repeat (gap) @(posedge clk);
			line <= ~line;
		end
	endtask
	// One received self-test bit; the data line flips once released
	task automatic st_send(input logic b);
		@(posedge clk);
		st_valid <= 1'b1;
		st_bit <= b;
		@(posedge clk);
		st_valid <= 1'b0;
		st_bit <= ~b;
	endtask
endmodule

// file: pd_bmc_timing_bist_rx_test.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
	num_errors++; $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module pd_bmc_timing_bist_rx_test;
	import pd_bmc_timing_pkg::*;
	localparam logic [7:0] PAT = 8'h2c;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] addr = '0;
	logic [7:0]  wdata = '0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  rdata;
	logic        rx_line;
	logic        active;
	logic        squelch;
	logic        tx_en = 1'b0;
	logic        tx_bit = 1'b0;
	logic        take;
	logic        tx_line;
	logic        st_valid;
	logic        st_bit;
	logic        st_en;
	logic [15:0] errors;
	int          num_errors = 0;
	int          comparisons = 0;

	always #2 clk = ~clk;

	cc_partner i_far (.clk(clk), .line(rx_line), .st_valid(st_valid),
		.st_bit(st_bit));
	pd_bmc_timing_bist_rx i_dut (
		.I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_RX_LINE(rx_line),
		.I_RX_HI_MAX(8'h05), .I_RX_LO_MAX(8'h09), .O_RX_ACTIVE(active),
		.O_RX_SQUELCH(squelch), .I_TX_EN(tx_en), .I_TX_BIT(tx_bit),
		.O_TX_BIT_TAKE(take), .O_TX_LINE(tx_line),
		.I_ST_BIT_VALID(st_valid), .I_ST_BIT(st_bit),
		.O_ST_RX_EN(st_en), .O_ST_ERRORS(errors));

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic chk_reg(input logic [15:0] a, input logic [7:0] ex);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK("rdata", ex, rdata)
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic t_regs();
		chk_reg(ADDR_SQ_HOLD, 8'h00);
		chk_reg(ADDR_TX_BIT, 8'h00);
		chk_reg(ADDR_WINDOW, 8'h00);
		chk_reg(ADDR_ST_CTL, 8'h00);
		wr_reg(ADDR_SQ_HOLD, 8'h17);
		wr_reg(ADDR_TX_BIT, 8'h9f);
		wr_reg(ADDR_WINDOW, 8'hc8);
		wr_reg(ADDR_ST_CTL, 8'hff);
		wr_reg(ADDR_ST_ERR_LO, 8'h55);
		chk_reg(ADDR_SQ_HOLD, 8'h17);
		chk_reg(ADDR_TX_BIT, 8'h9f);
		chk_reg(ADDR_WINDOW, 8'hc8);
		chk_reg(ADDR_ST_CTL, 8'h10);
		chk_reg(ADDR_ST_ERR_LO, 8'h00);
		chk_reg(16'h1aaa, 8'h00);
		`CHK("st_en", 1'b1, st_en)
		wr_reg(ADDR_ST_CTL, 8'h00);
		$display("test regs done");
	endtask

	task automatic t_window();
		wr_reg(ADDR_WINDOW, 8'h02);
		cyc(20);
		i_far.edges(3, 4);
		repeat (3) begin
			cyc(1);
			`CHK("active", 1'b0, active)
		end
		cyc(20);
		i_far.edges(3, 3);
		cyc(2);
		`CHK("active", 1'b1, active)
		cyc(20);
		`CHK("active", 1'b0, active)
		$display("test window done");
	endtask

	// Cycles from the last edge until squelch has risen and fallen again
	task automatic sq_run(input logic hi_end, output int n);
		bit seen;
		seen = 0;
		n = 0;
		i_far.edges((rx_line == hi_end) ? 4 : 3, 1);
		while (n < 300 && !(seen && squelch === 1'b0)) begin
			cyc(1);
			seen |= (squelch === 1'b1);
			n++;
		end
		cyc(40);
	endtask
	task automatic t_squelch();
		int a, b, c;
		wr_reg(ADDR_WINDOW, 8'h01);
		wr_reg(ADDR_SQ_HOLD, 8'h00);
		cyc(120);
		sq_run(1'b1, a);
		sq_run(1'b0, b);
		wr_reg(ADDR_SQ_HOLD, 8'h02);
		sq_run(1'b1, c);
		`CHK("low limit", a + 4, b)
		`CHK("hold", a + 8, c)
		$display("test squelch done");
	endtask

	task automatic tx_meas(input logic b, input logic [7:0] cnt);
		int per, tog, k;
		logic prev;
		per = 0;
		tog = 0;
		wr_reg(ADDR_TX_BIT, cnt);
		tx_bit <= b;
		tx_en <= 1'b1;
		repeat (2) begin
			cyc(1);
			k = 0;
			while (take !== 1'b1 && k < 300) begin
				cyc(1);
				k++;
			end
		end
		prev = tx_line;
		do begin
			cyc(1);
			per++;
			tog += (tx_line !== prev);
			prev = tx_line;
		end while (take !== 1'b1 && per < 600);
		`CHK("bit period", cnt + 1, per)
		`CHK("toggles", b ? 2 : 1, tog)
		@(posedge clk);
		tx_en <= 1'b0;
	endtask
	task automatic t_tx();
		tx_meas(1'b1, 8'h03);
		tx_meas(1'b0, 8'h03);
		tx_meas(1'b1, 8'h06);
		$display("test tx done");
	endtask

	task automatic st_pattern();
		i_far.st_send(1'b0);
		for (int i = 7; i >= 0; i--)
			i_far.st_send(PAT[i]);
		cyc(2);
	endtask
	task automatic t_selftest();
		logic [15:0] first;
		wr_reg(ADDR_ST_CTL, 8'h10);
		i_far.st_send(1'b0);
		cyc(2);
		chk_reg(ADDR_ST_ERR_LO, 8'h01);
		chk_reg(ADDR_ST_ERR_HI, 8'h00);
		wr_reg(ADDR_ST_CTL, 8'h00);
		wr_reg(ADDR_ST_CTL, 8'h10);
		st_pattern();
		first = errors;
		`CHK("errors pattern", 16'h0003, errors)
		wr_reg(ADDR_ST_CTL, 8'h10);
		cyc(2);
		`CHK("errors kept", first, errors)
		wr_reg(ADDR_ST_CTL, 8'h00);
		i_far.st_send(1'b0);
		cyc(2);
		`CHK("st_en", 1'b0, st_en)
		`CHK("errors idle", first, errors)
		wr_reg(ADDR_ST_CTL, 8'h10);
		cyc(1);
		`CHK("errors clear", 16'h0000, errors)
		st_pattern();
		`CHK("errors reseed", first, errors)
		$display("test selftest done");
	endtask

	initial begin
		#200000;
		num_errors++;
		close_out();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_window();
		t_squelch();
		t_tx();
		t_selftest();
		close_out();
	end
endmodule
